// ===== hdl/xbc_consts.svh
`ifndef XBC_CONSTS_SVH
`define XBC_CONSTS_SVH
// =====================================================================
// Register indices (byte address is four times the index)
`define XBC_IDX_CYCLE_CMD    18'h00000
`define XBC_IDX_CYCLE_DATA   18'h00001
`define XBC_IDX_CYCLE_STAT   18'h00002
`define XBC_IDX_BUS_CFG0     18'h00003
`define XBC_IDX_WIN_SEL1     18'h00008
`define XBC_IDX_SYSTEM_CTL   18'h0FF12
`define XBC_NUM_CFG          5
`define XBC_NUM_WIN          4
// =====================================================================
// bus_cycle_config fields
`define XBC_CFG_WAIT_LO      0
`define XBC_CFG_WAIT_HI      3
`define XBC_CFG_RDY_TYPE     3
`define XBC_CFG_CMD_DELAY    5
`define XBC_CFG_RDY_EN       12
`define XBC_CFG_RESET        16'h0000
// =====================================================================
// system_control fields
`define XBC_SYS_XBUS_SHARE   0
`define XBC_SYS_VISIBLE      1
`define XBC_SYS_PERIPH_EN    2
`define XBC_SYS_CLK_OUT_EN   8
`define XBC_SYS_RESET        16'h0000
`define XBC_SYS_WMASK        16'hFFDF
// =====================================================================
// Cycle command and status fields
`define XBC_CMD_WRITE        16
`define XBC_CMD_XBUS         17
`define XBC_STAT_BUSY        0
`define XBC_STAT_DONE        1
`define XBC_STAT_REFUSED     2
// =====================================================================
// Timing, one system clock is one half-clock unit
`define XBC_ALE_TCL          4'h2
`define XBC_WAIT_MAX_FULL    4'hF
`define XBC_WAIT_MAX_RDY     3'h7
// =====================================================================
// AXI responses
`define XBC_RESP_OKAY        2'h0
`define XBC_RESP_SLVERR      2'h2
`endif

// ===== hdl/xbc_pkg.sv
`default_nettype none
package xbc_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ALE  = 5'h02,
        ST_CMD  = 5'h04,
        ST_RDY  = 5'h08,
        ST_END  = 5'h10
    } xbc_state_e;

    typedef struct packed {
        xbc_state_e        state;
        logic [4:0]        half_clock_unit;
        logic              first;
        logic              rdy_seen;
        logic              sync1;
        logic              sync2;
        logic [15:0]       sys_ctl;
        logic [4:0][15:0]  cfg;
        logic [3:0][15:0]  win;
        logic [15:0]       cur_cfg;
        logic [15:0]       addr;
        logic              wr;
        logic [15:0]       wdata;
        logic [15:0]       rdata_cyc;
        logic              busy;
        logic              done;
        logic              refused;
        logic [2:0]        win_id;
        logic              aw_got;
        logic [17:0]       aw_idx;
        logic              w_got;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } xbc_state_s;
endpackage : xbc_pkg
`default_nettype wire

// ===== hdl/xbc_top.sv
// Implementation choice: register access over AXI4-Lite.
`include "xbc_consts.svh"
`default_nettype none
module xbc_top (
    // Clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    // AXI4-Lite slave
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [19:0] I_AWADDR,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    output logic [1:0]       O_BRESP,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    input  wire logic [19:0] I_ARADDR,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    // External bus pins
    output logic             O_ALE,
    output logic             O_RD_N,
    output logic             O_WR_N,
    output logic [15:0]      O_ADDR,
    input  wire logic [15:0] I_DATA,
    output logic [15:0]      O_DATA,
    output logic             O_DATA_OE_N,
    input  wire logic        I_READY_N,
    // XBUS sharing and global controls
    input  wire logic        I_HOLD_ACK,
    input  wire logic        I_EXT_XBUS_REQ,
    output logic             O_EXT_XBUS_GRANT,
    output logic             O_XBUS_PERIPH_EN,
    output logic             O_SYS_CLOCK_OUT_EN
);

    // =================================================================
    // Helpers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Window match: base in [15:8], size code in [2:0] masks low base bits
    function automatic logic win_hit(input logic [15:0] sel, input logic [15:0] a);
        logic [7:0] m;
        m = 8'hFF << sel[2:0];
        win_hit = ((a[15:8] & m) == (sel[15:8] & m));
    endfunction

    function automatic logic [3:0] wait_states(input logic [15:0] c);
        if (c[`XBC_CFG_RDY_EN])
            wait_states = {1'b0, `XBC_WAIT_MAX_RDY - c[2:0]};
        else
            wait_states = `XBC_WAIT_MAX_FULL - c[`XBC_CFG_WAIT_HI:`XBC_CFG_WAIT_LO];
    endfunction

    // =================================================================
    // State
    xbc_pkg::xbc_state_s r;
    xbc_pkg::xbc_state_s next_r;

    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic [17:0] ar_idx;
    logic [3:0]  ws;
    logic        delay_on;
    logic        rdy_async;
    logic        rdy_active;
    logic        strobe;
    logic [15:0] sel_cfg;
    logic [2:0]  sel_id;

    assign aw_take  = I_AWVALID && !r.aw_got;
    assign w_take   = I_WVALID && !r.w_got;
    assign ar_take  = I_ARVALID && !r.rvalid;
    assign ar_idx   = I_ARADDR[19:2];
    assign ws       = wait_states(r.cur_cfg);
    assign delay_on = !r.cur_cfg[`XBC_CFG_CMD_DELAY];
    assign rdy_async = r.cur_cfg[`XBC_CFG_RDY_TYPE];
    // Async path only looks at the second synchroniser stage
    assign rdy_active = rdy_async ? !r.sync2 : !I_READY_N;
    // Command phase: strobe held off during first half-clock if delayed
    assign strobe = (r.state == xbc_pkg::ST_CMD || r.state == xbc_pkg::ST_RDY)
                    && !(r.first && delay_on);

    // Window decode, lowest window number wins on overlap
    always_comb
    begin
        sel_cfg = r.cfg[0];
        sel_id  = 3'h0;
        for (int i = `XBC_NUM_WIN - 1; i >= 0; i--)
        begin
            if (win_hit(r.win[i], r.addr))
            begin
                sel_cfg = r.cfg[i + 1];
                sel_id  = 3'(i + 1);
            end
        end
    end

    // =================================================================
    // Next state
    always_comb
    begin
        logic wr_go;
        logic [17:0] widx;
        logic start;
        wr_go  = 1'b0;
        widx   = r.aw_idx;
        start  = 1'b0;
        next_r = r;

        // Synchroniser for asynchronous ready
        next_r.sync1 = I_READY_N;
        next_r.sync2 = r.sync1;

        // AXI write address and data, taken in either order
        if (aw_take)
        begin
            next_r.aw_got = 1'b1;
            next_r.aw_idx = I_AWADDR[19:2];
        end
        if (w_take)
        begin
            next_r.w_got  = 1'b1;
            next_r.w_data = I_WDATA;
            next_r.w_strb = I_WSTRB;
        end
        if (I_BREADY && r.bvalid)
            next_r.bvalid = 1'b0;
        if (r.aw_got && r.w_got && !r.bvalid)
        begin
            wr_go         = 1'b1;
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = `XBC_RESP_OKAY;
        end

        if (wr_go)
        begin
            if (widx == `XBC_IDX_CYCLE_CMD)
            begin
                // Ignored while a cycle runs: a hung ready cycle keeps busy until reset
                if (!r.busy)
                begin
                    next_r.addr = merge16(r.addr, r.w_data, r.w_strb[1:0]);
                    if (r.w_strb[2])
                    begin
                        next_r.wr = r.w_data[`XBC_CMD_WRITE];
                        start     = 1'b1;
                        if (r.w_data[`XBC_CMD_XBUS] && !r.sys_ctl[`XBC_SYS_PERIPH_EN])
                            start = 1'b0;
                        else if (r.w_data[`XBC_CMD_XBUS] && !r.sys_ctl[`XBC_SYS_VISIBLE])
                            start = 1'b0;
                    end
                end
            end
            else if (widx == `XBC_IDX_CYCLE_DATA)
                next_r.wdata = merge16(r.wdata, r.w_data, r.w_strb[1:0]);
            else if (widx == `XBC_IDX_CYCLE_STAT)
            begin
                if (r.w_strb[0] && r.w_data[`XBC_STAT_DONE])
                    next_r.done = 1'b0;
                if (r.w_strb[0] && r.w_data[`XBC_STAT_REFUSED])
                    next_r.refused = 1'b0;
            end
            else if (widx >= `XBC_IDX_BUS_CFG0 && widx < `XBC_IDX_BUS_CFG0 + `XBC_NUM_CFG)
                next_r.cfg[3'(widx - `XBC_IDX_BUS_CFG0)] =
                    merge16(r.cfg[3'(widx - `XBC_IDX_BUS_CFG0)], r.w_data, r.w_strb[1:0]);
            else if (widx >= `XBC_IDX_WIN_SEL1 && widx < `XBC_IDX_WIN_SEL1 + `XBC_NUM_WIN)
                next_r.win[2'(widx - `XBC_IDX_WIN_SEL1)] =
                    merge16(r.win[2'(widx - `XBC_IDX_WIN_SEL1)], r.w_data, r.w_strb[1:0]);
            else if (widx == `XBC_IDX_SYSTEM_CTL)
                next_r.sys_ctl = merge16(r.sys_ctl, r.w_data, r.w_strb[1:0])
                                 & `XBC_SYS_WMASK;
            else
                next_r.bresp = `XBC_RESP_SLVERR;
        end

        // AXI read
        if (I_RREADY && r.rvalid)
            next_r.rvalid = 1'b0;
        if (ar_take)
        begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = `XBC_RESP_OKAY;
            next_r.rdata  = 32'h0000_0000;
            if (ar_idx == `XBC_IDX_CYCLE_CMD)
                next_r.rdata = {14'h0000, 1'b0, r.wr, r.addr};
            else if (ar_idx == `XBC_IDX_CYCLE_DATA)
                next_r.rdata = {16'h0000, r.rdata_cyc};
            else if (ar_idx == `XBC_IDX_CYCLE_STAT)
                next_r.rdata = {25'h0000000, r.win_id, 1'b0, r.refused, r.done, r.busy};
            else if (ar_idx >= `XBC_IDX_BUS_CFG0 && ar_idx < `XBC_IDX_BUS_CFG0 + `XBC_NUM_CFG)
                next_r.rdata = {16'h0000, r.cfg[3'(ar_idx - `XBC_IDX_BUS_CFG0)]};
            else if (ar_idx >= `XBC_IDX_WIN_SEL1 && ar_idx < `XBC_IDX_WIN_SEL1 + `XBC_NUM_WIN)
                next_r.rdata = {16'h0000, r.win[2'(ar_idx - `XBC_IDX_WIN_SEL1)]};
            else if (ar_idx == `XBC_IDX_SYSTEM_CTL)
                next_r.rdata = {16'h0000, r.sys_ctl};
            else
                next_r.rresp = `XBC_RESP_SLVERR;
        end

        // Cycle engine
        next_r.first = 1'b0;
        unique case (r.state)
            xbc_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    next_r.busy  = 1'b1;
                    next_r.state = xbc_pkg::ST_ALE;
                    next_r.half_clock_unit   = 5'h00;
                end
            end
            xbc_pkg::ST_ALE:
            begin
                next_r.cur_cfg = sel_cfg;
                next_r.win_id  = sel_id;
                next_r.half_clock_unit     = r.half_clock_unit + 5'h01;
                if (r.half_clock_unit == {1'b0, `XBC_ALE_TCL - 4'h1})
                begin
                    next_r.half_clock_unit      = 5'h00;
                    next_r.first    = 1'b1;
                    next_r.rdy_seen = 1'b0;
                    next_r.state    = xbc_pkg::ST_CMD;
                    // No waitstates: ready sampling starts with the command
                    if (ws == 4'h0 && r.cur_cfg[`XBC_CFG_RDY_EN])
                        next_r.state = xbc_pkg::ST_RDY;
                end
            end
            xbc_pkg::ST_CMD:
            begin
                // Length set by waitstates only; delay just trims the strobe front
                next_r.half_clock_unit = r.half_clock_unit + 5'h01;
                if (r.cur_cfg[`XBC_CFG_RDY_EN] && r.half_clock_unit == {ws, 1'b0} - 5'h01)
                begin
                    next_r.half_clock_unit   = 5'h00;
                    next_r.state = xbc_pkg::ST_RDY;
                end
                else if (!r.cur_cfg[`XBC_CFG_RDY_EN] && r.half_clock_unit == {ws, 1'b1})
                    next_r.state = xbc_pkg::ST_END;
                if (!r.cur_cfg[`XBC_CFG_RDY_EN] || next_r.state == xbc_pkg::ST_RDY)
                    next_r.rdata_cyc = I_DATA;
            end
            xbc_pkg::ST_RDY:
            begin
                // One CPU clock per sample, no timeout: a silent device hangs here
                next_r.half_clock_unit = {4'h0, ~r.half_clock_unit[0]};
                if (rdy_async && !r.half_clock_unit[0] && rdy_active)
                    next_r.rdy_seen = 1'b1;
                if ((rdy_async && r.half_clock_unit[0] && r.rdy_seen) || (!rdy_async && r.half_clock_unit[0] && rdy_active))
                    next_r.state = xbc_pkg::ST_END;
                next_r.rdata_cyc = I_DATA;
            end
            xbc_pkg::ST_END:
            begin
                next_r.busy  = 1'b0;
                next_r.state = xbc_pkg::ST_IDLE;
            end
            default:
                next_r.state = xbc_pkg::ST_IDLE;
        endcase

        // Sticky results: hardware set beats a simultaneous software clear
        if (r.state == xbc_pkg::ST_END)
            next_r.done = 1'b1;
        if (start == 1'b0 && wr_go && widx == `XBC_IDX_CYCLE_CMD && !r.busy && r.w_strb[2]
            && r.w_data[`XBC_CMD_XBUS])
        begin
            if (!r.sys_ctl[`XBC_SYS_PERIPH_EN])
                next_r.refused = 1'b1;
            else
                next_r.done = 1'b1;
        end
        // Visible XBUS accesses take the normal external path
        if (start && r.w_data[`XBC_CMD_XBUS])
            next_r.busy = r.sys_ctl[`XBC_SYS_VISIBLE];
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            r         <= '0;
            r.state   <= xbc_pkg::ST_IDLE;
            r.sync1   <= 1'b1;
            r.sync2   <= 1'b1;
            r.sys_ctl <= `XBC_SYS_RESET;
            r.cfg     <= {`XBC_NUM_CFG{`XBC_CFG_RESET}};
        end
        else
            r <= next_r;
    end

    // =================================================================
    // Outputs
    assign O_AWREADY   = !r.aw_got;
    assign O_WREADY    = !r.w_got;
    assign O_BVALID    = r.bvalid;
    assign O_BRESP     = r.bresp;
    assign O_ARREADY   = !r.rvalid;
    assign O_RVALID    = r.rvalid;
    assign O_RDATA     = r.rdata;
    assign O_RRESP     = r.rresp;
    assign O_ALE       = (r.state == xbc_pkg::ST_ALE);
    assign O_RD_N      = !(strobe && !r.wr);
    assign O_WR_N      = !(strobe && r.wr);
    assign O_ADDR      = r.addr;
    assign O_DATA      = r.wdata;
    assign O_DATA_OE_N = !(r.wr && (r.state == xbc_pkg::ST_CMD || r.state == xbc_pkg::ST_RDY));
    // External masters reach XBUS peripherals only while the bus is held
    assign O_EXT_XBUS_GRANT = r.sys_ctl[`XBC_SYS_XBUS_SHARE] && r.sys_ctl[`XBC_SYS_PERIPH_EN]
                              && I_HOLD_ACK && I_EXT_XBUS_REQ;
    assign O_XBUS_PERIPH_EN   = r.sys_ctl[`XBC_SYS_PERIPH_EN];
    assign O_SYS_CLOCK_OUT_EN = r.sys_ctl[`XBC_SYS_CLK_OUT_EN];

endmodule // xbc_top
`default_nettype wire

// ===== verif/xbc_checker.sv
`default_nettype none
module xbc_checker (
    // Clock and reset
    input wire logic        I_SYS_CLK,
    input wire logic        I_RST,
    // Register bus
    input wire logic        O_ARREADY,
    input wire logic        O_BVALID,
    input wire logic        I_BREADY,
    input wire logic        O_RVALID,
    input wire logic        I_RREADY,
    // External bus
    input wire logic        O_ALE,
    input wire logic        O_RD_N,
    input wire logic        O_WR_N,
    input wire logic [15:0] O_ADDR
);
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);
    logic strobe;
    assign strobe = !O_RD_N || !O_WR_N;
    // =====================================================================
    // Cycle steps
    sequence ale_pulse;
        O_ALE [*2] ##1 !O_ALE;
    endsequence
    sequence cmd_start;
        ##[0:1] strobe;
    endsequence
    a_ale_width : assert property ($rose(O_ALE) |-> ale_pulse)
        else $error("address latch pulse not two clocks");
    a_strobe_delay : assert property ($fell(O_ALE) |-> cmd_start)
        else $error("strobe late after latch fall");
    a_quiet_latch : assert property (O_ALE |-> !strobe)
        else $error("strobe during latch pulse");
    a_one_strobe : assert property (!(!O_RD_N && !O_WR_N))
        else $error("both strobes active");
    a_addr_hold : assert property (strobe && $past(strobe) |-> $stable(O_ADDR))
        else $error("address moved under strobe");
    a_end_gap : assert property ($rose(O_RD_N) || $rose(O_WR_N) |-> !O_ALE [*2])
        else $error("new cycle without end clock");
    // =====================================================================
    // Register bus answers hold until taken
    a_bvalid_hold : assert property (O_BVALID && !I_BREADY |=> O_BVALID)
        else $error("write response dropped");
    a_rvalid_hold : assert property (O_RVALID && !I_RREADY |=> O_RVALID)
        else $error("read response dropped");
    a_read_block : assert property (O_RVALID |-> !O_ARREADY)
        else $error("read address taken while answering");
endmodule // xbc_checker
bind xbc_top xbc_checker u_chk (
    .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .O_ARREADY(O_ARREADY), .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_ALE(O_ALE),
    .O_RD_N(O_RD_N), .O_WR_N(O_WR_N), .O_ADDR(O_ADDR)
);
`default_nettype wire

// ===== verif/xbc_ext_dev.sv
`default_nettype none
module xbc_ext_dev (
    // Bus side
    input  wire logic        clk,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] addr,
    input  wire logic [3:0]  dly,
    // Answers
    output logic [15:0]      data,
    output logic             ready_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  cnt = 4'h0;
    logic [15:0] last = 16'h0000;
    always @(posedge clk)
    begin
        cnt <= (rd_n && wr_n) ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
        if (!rd_n) last <= addr ^ 16'h5A5A;
    end
    // Ready low after dly strobe clocks, never for 4'hF; pulled up once strobe rises
    assign ready_n = (rd_n && wr_n) || dly == 4'hF || cnt < dly;
    // A released data bus shows the inverse of the last value, not a stale copy
    assign data = rd_n ? ~last : addr ^ 16'h5A5A;
endmodule // xbc_ext_dev
`default_nettype wire

// ===== verif/xbc_top_test.sv
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module xbc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic        hold = 1'b0, req = 1'b0, awr, wry, bv, arr, rv, ale, rdn, wrn, oen, rdyn, gnt, pen, cken;
    logic [19:0] awa = 20'h0, ara = 20'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic [3:0]  dly = 4'h0;
    logic        clr = 1'b0;
    logic [1:0]  br, rr;
    logic [15:0] oad, oda, ida;
    int          error_cnt = 0, tests_run = 0, gap = 0, slen = 0;
    initial
    begin
        forever #5 clk = ~clk;
    end
    xbc_top dut (.I_SYS_CLK(clk), .I_RST(rst), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
        .I_WVALID(wv), .O_WREADY(wry), .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv), .I_BREADY(bry),
        .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry),
        .O_RDATA(rdat), .O_RRESP(rr), .O_ALE(ale), .O_RD_N(rdn), .O_WR_N(wrn), .O_ADDR(oad), .I_DATA(ida),
        .O_DATA(oda), .O_DATA_OE_N(oen), .I_READY_N(rdyn), .I_HOLD_ACK(hold), .I_EXT_XBUS_REQ(req),
        .O_EXT_XBUS_GRANT(gnt), .O_XBUS_PERIPH_EN(pen), .O_SYS_CLOCK_OUT_EN(cken));
    xbc_ext_dev ext (.clk(clk), .rd_n(rdn), .wr_n(wrn), .addr(oad), .dly(dly), .data(ida), .ready_n(rdyn));
    // Latch-to-strobe gap and strobe length of the last cycle
    // 999 marks a command that never reached the pins
    always @(posedge clk)
        if (clr) slen <= 999;
        else if (ale)
        begin
            gap <= 0;
            slen <= 0;
        end
        else if (!rdn || !wrn) slen <= slen + 1;
        else if (slen == 0) gap <= gap + 1;
    // =====================================================================
    // Bus tasks
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n > 2000)
        begin
            error_cnt++;
            $display("ERROR timeout expected 0 seen 1");
            results();
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wry) wv <= 1'b0;
            tmo(n++);
        end while (!bv);
        r = br;
        bry <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            tmo(n++);
        end while (!rv);
        d = rdat;
        r = rr;
        rry <= 1'b0;
    endtask
    task automatic cyc(input logic [15:0] a, input logic w, input logic x, output logic [31:0] st);
        logic [1:0] r;
        int         n;
        n = 0;
        clr <= 1'b1;
        wr(20'h00000, {14'h0, x, w, a}, r);
        clr <= 1'b0;
        do
        begin
            rd(20'h00008, st, r);
            tmo(n++);
        end while (st[1] !== 1'b1);
        wr(20'h00008, 32'h6, r);
    endtask
    // =====================================================================
    // Scenarios
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        rd(20'h0000C, d, r);
        `CHK("cfg0", 32'h0, d)
        rd(20'h3FC48, d, r);
        `CHK("sysctl", 32'h0, d)
        hold <= 1'b1;
        req <= 1'b1;
        wr(20'h3FC48, 32'hFFFF, r);
        `CHK("wresp", 2'h0, r)
        rd(20'h3FC48, d, r);
        `CHK("sysctl", 32'h0000FFDF, d)
        `CHK("periph", 1'b1, pen)
        `CHK("sys_clock_out", 1'b1, cken)
        `CHK("grant", 1'b1, gnt)
        wr(20'h3FC48, 32'hFFFE, r);
        rd(20'h00400, d, r);
        `CHK("grant", 1'b0, gnt)
        `CHK("resp", 2'h2, r)
    endtask
    task automatic t_delay;
        logic [15:0] cf [4];
        logic [31:0] st;
        logic [1:0]  r;
        int          ws, dl;
        cf = '{16'h0000, 16'h0020, 16'h000F, 16'h002F};
        for (int i = 0; i < 4; i++)
        begin
            ws = 15 - cf[i][3:0];
            dl = !cf[i][5];
            wr(20'h0000C, {16'h0, cf[i]}, r);
            wr(20'h00004, 32'h0000BEEF, r);
            cyc(16'h1234, i[0], 1'b0, st);
            `CHK("gap", dl, gap)
            `CHK("strobe", 2 * (1 + ws) - dl, slen)
            `CHK("bus", i[0] ? 16'hBEEF : 16'h1234, i[0] ? oda : oad)
            if (!i[0])
            begin
                rd(20'h00004, st, r);
                `CHK("rdata", 32'h0000486E, st)
            end
        end
    endtask
    task automatic t_window;
        logic [31:0] st;
        logic [1:0]  r;
        wr(20'h00020, 32'h4000, r);
        wr(20'h00010, 32'h002F, r);
        wr(20'h0000C, 32'h0020, r);
        cyc(16'h4012, 1'b0, 1'b0, st);
        `CHK("window", 3'h1, st[6:4])
        `CHK("strobe", 2, slen)
        cyc(16'h1000, 1'b0, 1'b0, st);
        `CHK("window", 3'h0, st[6:4])
        `CHK("strobe", 32, slen)
    endtask
    task automatic t_xbus;
        logic [31:0] st;
        logic [1:0]  r;
        wr(20'h3FC48, 32'h0000, r);
        wr(20'h00000, 32'h00022000, r);
        rd(20'h00008, st, r);
        `CHK("refused", 3'h4, st[2:0])
        wr(20'h00008, 32'h6, r);
        wr(20'h3FC48, 32'h0004, r);
        cyc(16'h2000, 1'b0, 1'b1, st);
        `CHK("hidden", 999, slen)
        wr(20'h3FC48, 32'h0006, r);
        cyc(16'h2000, 1'b0, 1'b1, st);
        `CHK("visible", 1'b1, slen != 999)
    endtask
    task automatic t_ready;
        logic [31:0] st;
        logic [1:0]  r;
        wr(20'h0000C, 32'h1025, r);
        cyc(16'h3000, 1'b0, 1'b0, st);
        `CHK("sync", 6, slen)
        dly <= 4'h9;
        cyc(16'h3000, 1'b0, 1'b0, st);
        `CHK("late", 10, slen)
        wr(20'h0000C, 32'h102D, r);
        cyc(16'h3000, 1'b0, 1'b0, st);
        `CHK("async", 1'b1, slen > 10)
        dly <= 4'hF;
        wr(20'h00000, 32'h13000, r);
        repeat (200) @(posedge clk);
        rd(20'h00008, st, r);
        `CHK("stall", 3'h4, {st[0], wrn, oen})
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("reset", 2'h3, {wrn, oen})
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_delay();
        t_window();
        t_xbus();
        t_ready();
        results();
    end
endmodule // xbc_top_test
`default_nettype wire
